// *** logic/spimc_consts.vh ***
// Constants for the host-side serial port controller.
`ifndef SPIMC_CONSTS_VH
`define SPIMC_CONSTS_VH
// ==========================================================
// Register word offsets (byte addresses on the APB)
`define SPIMC_ADDR_CTRL 12'h000
`define SPIMC_ADDR_STAT 12'h004
`define SPIMC_ADDR_TXD 12'h008
`define SPIMC_ADDR_RXD 12'h00c
`define SPIMC_ADDR_SEL 12'h010
// ==========================================================
// Control register fields
`define SPIMC_CTRL_RATE_LO 0
`define SPIMC_CTRL_RATE_HI 2
`define SPIMC_CTRL_IDLE 3
`define SPIMC_CTRL_PHASE 4
`define SPIMC_CTRL_ENABLE 5
`define SPIMC_CTRL_RST 6'h04
`define SPIMC_CTRL_W 6
// ==========================================================
// Status register fields
`define SPIMC_STAT_DONE 0
`define SPIMC_STAT_BUSY 1
`define SPIMC_STAT_COLL 2
`define SPIMC_STAT_BADRATE 3
// ==========================================================
// Rate codes and widths
`define SPIMC_RATE_RES0 3'h0
`define SPIMC_RATE_RES7 3'h7
`define SPIMC_BITS 4'h8
`define SPIMC_LAST_BIT 4'h7
`define SPIMC_SEL_RST 4'hf
`endif

// *** logic/spimc_clkgen.v ***
// Serial clock half-period tick generator for the host controller.
`timescale 1ns/100ps
module spimc_clkgen
(
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire run_in,
  input wire [2:0] rate_in,
  output reg tick_out
);
`include "spimc_consts.vh"
  reg [6:0] cnt;
  // Half the divisor is 2 << (rate - 1), that is 1 << rate.
  wire [6:0] half = (7'h01 << rate_in) - 7'h01;
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt <= 7'h00;
      tick_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (!run_in)
      begin
        cnt <= 7'h00;
        tick_out <= 1'b0;
      end
      else if (cnt >= half)
      begin
        cnt <= 7'h00;
        tick_out <= 1'b1;
      end
      else
      begin
        cnt <= cnt + 7'h01;
        tick_out <= 1'b0;
      end
    end
  end
endmodule // spimc_clkgen

// *** logic/spimc_top.v ***
// Host-side serial port master driving a device over its four serial pins.
// Functional notes
// - Bytes travel as eight bits, most significant bit first.
// - Master runs exactly eight serial clock cycles per byte.
// - Master holds one slave's select low for each byte, and across bytes only in phase 1.
// - Do not enable select-disable while clock phase is 0.
// - Master drives select low before and during each transfer.
// - Slave software must read data before the next byte arrives.
// - Change role, polarity or phase only while disabled.
// - Slave serial clock must not exceed the device bus clock.
// - Phase 0: first edge captures MSB; select toggles between bytes.
// - Phase 1: master drives on first edge; select may stay low.
`timescale 1ns/100ps
module spimc_top
#(
  parameter SEL_W = 4
)
(
  input wire clk_in,
  input wire rstn_in,
  input wire ce_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  output reg sclk_out,
  output reg mosi_out,
  input wire miso_in,
  output reg [SEL_W-1:0] sel_n_out
);
`include "spimc_consts.vh"
  // ==========================================================
  // State encoding
  localparam ST_IDLE = 3'b001;
  localparam ST_LEAD = 3'b010;
  localparam ST_SHIFT = 3'b100;
  // ==========================================================
  // Registers
  reg [`SPIMC_CTRL_W-1:0] ctrl;
  reg [SEL_W-1:0] sel_mask;
  reg [7:0] tx_hold;
  reg [7:0] rx_data;
  reg [7:0] shreg;
  reg done_flag;
  reg coll_flag;
  reg stat_seen;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg phase_half;
  reg miso_s1;
  reg miso_s2;
  wire tick;
  wire [2:0] rate = ctrl[`SPIMC_CTRL_RATE_HI:`SPIMC_CTRL_RATE_LO];
  wire idle_lvl = ctrl[`SPIMC_CTRL_IDLE];
  wire clock_edge_phase = ctrl[`SPIMC_CTRL_PHASE];
  wire enabled = ctrl[`SPIMC_CTRL_ENABLE];
  wire bad_rate = (rate == `SPIMC_RATE_RES0) || (rate == `SPIMC_RATE_RES7);
  wire busy = (state != ST_IDLE);
  wire acc = psel_in && penable_in && !pready_out;
  // Writes land on the edge that completes the transfer, the one at which the master sees ready.
  wire apb_done = psel_in && penable_in && pready_out;
  wire wr = apb_done && pwrite_in;
  wire rd = acc && !pwrite_in;

  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // A mask may assert at most one line, so two slaves never fight over the data input.
  function single_sel;
    input [SEL_W-1:0] m;
    integer k;
    integer zeros;
    begin
      zeros = 0;
      for (k = 0; k < SEL_W; k = k + 1)
        zeros = zeros + (m[k] ? 0 : 1);
      single_sel = (zeros <= 1);
    end
  endfunction

  wire sel_ok = single_sel(pwdata_in[SEL_W-1:0]);
  wire sel_refused = pwrite_in && hit(paddr_in, `SPIMC_ADDR_SEL) && !sel_ok;
  wire wr_txd = wr && hit(paddr_in, `SPIMC_ADDR_TXD);
  wire wr_ctrl = wr && hit(paddr_in, `SPIMC_ADDR_CTRL);
  wire wr_sel = wr && hit(paddr_in, `SPIMC_ADDR_SEL);
  wire rd_stat = rd && hit(paddr_in, `SPIMC_ADDR_STAT);
  wire rd_rxd = rd && hit(paddr_in, `SPIMC_ADDR_RXD);
  wire mapped = hit(paddr_in, `SPIMC_ADDR_CTRL) || hit(paddr_in, `SPIMC_ADDR_STAT) ||
    hit(paddr_in, `SPIMC_ADDR_TXD) || hit(paddr_in, `SPIMC_ADDR_RXD) ||
    hit(paddr_in, `SPIMC_ADDR_SEL);
  wire start = wr_txd && !busy && enabled && !bad_rate;
  wire finish = (state == ST_SHIFT) && enabled && tick && phase_half &&
    (bitcnt == `SPIMC_LAST_BIT);

  spimc_clkgen u_clkgen
  (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .run_in(busy),
    .rate_in(rate),
    .tick_out(tick)
  );

  // ==========================================================
  // Input synchroniser
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end
    else if (ce_in)
    begin
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
    end
  end

  // ==========================================================
  // APB slave
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl <= `SPIMC_CTRL_RST;
      sel_mask <= {SEL_W{1'b1}};
      tx_hold <= 8'h00;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
    else if (ce_in)
    begin
      pready_out <= acc;
      pslverr_out <= acc && (!mapped || sel_refused);
      prdata_out <= 32'h0000_0000;
      if (wr_ctrl && !busy)
        ctrl <= pwdata_in[`SPIMC_CTRL_W-1:0];
      // While busy only a cleared enable gets through, so software can still abort a byte.
      else if (wr_ctrl && !pwdata_in[`SPIMC_CTRL_ENABLE])
        ctrl[`SPIMC_CTRL_ENABLE] <= 1'b0;
      // The select is only retargeted between bytes, so a slave stays held.
      if (wr_sel && !busy && sel_ok)
        sel_mask <= pwdata_in[SEL_W-1:0];
      if (start)
        tx_hold <= pwdata_in[7:0];
      if (rd)
      begin
        if (hit(paddr_in, `SPIMC_ADDR_CTRL))
          prdata_out <= {26'h0, ctrl};
        else if (hit(paddr_in, `SPIMC_ADDR_STAT))
          prdata_out <= {28'h0, bad_rate, coll_flag, busy, done_flag};
        else if (hit(paddr_in, `SPIMC_ADDR_TXD))
          prdata_out <= {24'h0, tx_hold};
        else if (hit(paddr_in, `SPIMC_ADDR_RXD))
          prdata_out <= {24'h0, rx_data};
        else if (hit(paddr_in, `SPIMC_ADDR_SEL))
          prdata_out <= {{(32-SEL_W){1'b0}}, sel_mask};
      end
    end
  end

  // ==========================================================
  // Flags
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      done_flag <= 1'b0;
      coll_flag <= 1'b0;
      stat_seen <= 1'b0;
      rx_data <= 8'h00;
    end
    else if (ce_in)
    begin
      if (rd_stat)
        stat_seen <= done_flag || coll_flag;
      else if (rd_rxd)
        stat_seen <= 1'b0;
      if (finish)
      begin
        done_flag <= 1'b1;
        // Phase 1 takes its last bit on this very edge.
        rx_data <= clock_edge_phase ? {shreg[6:0], miso_s2} : shreg;
      end
      else if (rd_rxd && stat_seen)
        done_flag <= 1'b0;
      if (wr_txd && busy)
        coll_flag <= 1'b1;
      else if (rd_rxd && stat_seen)
        coll_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Serial engine
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      phase_half <= 1'b0;
      shreg <= 8'h00;
      sclk_out <= 1'b0;
      mosi_out <= 1'b0;
      sel_n_out <= {SEL_W{1'b1}};
    end
    else if (ce_in)
    begin
      case (state)
        ST_IDLE:
        begin
          sclk_out <= idle_lvl;
          // Phase 0 needs select raised between bytes.
          sel_n_out <= {SEL_W{1'b1}};
          if (clock_edge_phase)
            sel_n_out <= sel_mask;
          if (start)
          begin
            shreg <= pwdata_in[7:0];
            mosi_out <= pwdata_in[7];
            sel_n_out <= sel_mask;
            bitcnt <= 4'h0;
            phase_half <= 1'b0;
            state <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          // One half period here, one more in shift: two half periods of setup after select falls, before any edge.
          if (!enabled)
            state <= ST_IDLE;
          else if (tick)
            state <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (!enabled)
            state <= ST_IDLE;
          else if (tick)
          begin
            sclk_out <= ~sclk_out;
            phase_half <= ~phase_half;
            // Leading edges in phase 1 drive from the second bit, trailing edges in phase 0.
            if (!phase_half ^ clock_edge_phase)
              shreg <= {shreg[6:0], miso_s2};
            else if (!(clock_edge_phase && bitcnt == 4'h0))
              mosi_out <= shreg[7];
            if (phase_half)
            begin
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == `SPIMC_LAST_BIT)
                state <= ST_IDLE;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule // spimc_top

// *** test/spimc_props.sv ***
// Pin-level checks for the serial port master.
`timescale 1ns/100ps
module spimc_props
#(
  parameter SEL_W = 4
)
(
  input wire clk_in,
  input wire rstn_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire sclk_out,
  input wire [SEL_W-1:0] sel_n_out
);
  // ====
  // Clock edges counted per selection.
  reg [3:0] tgl;
  reg sclk_d;
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      tgl <= 4'h0;
      sclk_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_out;
      tgl <= (&sel_n_out) ? 4'h0 : tgl + {3'h0, sclk_out ^ sclk_d};
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_ANSWER: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no ready");
  AST_PULSE: assert property (pready_out |=> !pready_out)
    else $error("long ready");
  AST_RDATA: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("stray data");
  AST_SLVERR: assert property (pslverr_out |-> pready_out)
    else $error("stray error");
  AST_START: assert property ($fell(&sel_n_out) |->
    $past(psel_in && penable_in && pwrite_in) || $past(psel_in && penable_in && pwrite_in, 2))
    else $error("select without write");
  AST_QUIET: assert property ($changed(sel_n_out) |-> $stable(sclk_out))
    else $error("select moved on a clock edge");
  AST_GAP: assert property ($changed(sclk_out) |=> $stable(sclk_out))
    else $error("half period too short");
  AST_COUNT: assert property ($rose(&sel_n_out) |-> tgl == 4'h0)
    else $error("partial byte");
endmodule // spimc_props
bind spimc_top spimc_props #(.SEL_W(SEL_W)) u_props (.clk_in(clk_in), .rstn_in(rstn_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .sclk_out(sclk_out),
  .sel_n_out(sel_n_out));

// *** test/spimc_slave.sv ***
// Behavioural model of the serial device on select line zero.
`timescale 1ns/100ps
module spimc_slave
(
  input wire sclk_in,
  input wire mosi_in,
  input wire sel_n_in,
  input wire clock_idle_level_in,
  input wire clock_edge_phase_in,
  input wire [7:0] tx_in,
  output reg miso_out,
  output reg [7:0] rx_out
);
  // ====
  // Shift core.
  // Only ever a slave, so its master-mode fault paths stay idle.
  reg [7:0] sh;
  reg [3:0] n;
  initial
  begin
    miso_out = 1'b0;
    rx_out = 8'h00;
    n = 4'h8;
  end
  // A floating line is shown as the inverse of its last level.
  always @(posedge sel_n_in)
    miso_out = ~miso_out;
  always @(negedge sel_n_in)
  begin
    sh = tx_in;
    n = 4'h0;
    miso_out = sh[7];
  end
  always @(sclk_in)
    if (!sel_n_in && ((sclk_in != clock_idle_level_in) ^ clock_edge_phase_in))
    begin
      sh = {sh[6:0], mosi_in};
      n = n + 4'h1;
      if (n == 4'h8)
        rx_out = sh;
    end
    else if (!sel_n_in)
    begin
      if (n == 4'h8)
      begin
        sh = tx_in;
        n = 4'h0;
      end
      miso_out = sh[7];
    end
endmodule // spimc_slave

// *** test/tb.sv ***
// Self-checking bench for the serial port master.
`timescale 1ns/100ps
`include "spimc_consts.vh"
module tb;
  // ====
  // Stimulus and checking.
  reg clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, clock_idle_level = 1'b0, clock_edge_phase = 1'b0;
  reg [11:0] pa = 12'h000;
  reg [31:0] pwd = 32'h0;
  reg [7:0] stx = 8'h00;
  reg [31:0] rd;
  reg er;
  integer miscompares = 0, num_checks = 0, cyc = 0, i, n;
  wire [31:0] prd;
  wire prdy, perr, sclk, mosi, miso;
  wire [3:0] sel_n;
  wire [7:0] srx;
  spimc_top #(.SEL_W(4)) dut (.clk_in(clk), .rstn_in(rstn), .ce_in(1'b1), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .sclk_out(sclk), .mosi_out(mosi), .miso_in(miso),
    .sel_n_out(sel_n));
  spimc_slave dev (.sclk_in(sclk), .mosi_in(mosi), .sel_n_in(sel_n[0]), .clock_idle_level_in(clock_idle_level),
    .clock_edge_phase_in(clock_edge_phase), .tx_in(stx), .miso_out(miso), .rx_out(srx));
  initial
  begin
    forever #20 clk = ~clk;
  end
  task wrap_up;
  begin
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
  begin
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  end
  endtask
  task bad_rate(input [2:0] r);
  begin
    apb(1'b1, `SPIMC_ADDR_CTRL, {26'h0, 1'b1, 2'b00, r});
    apb(1'b1, `SPIMC_ADDR_TXD, 32'h5a);
    apb(1'b0, `SPIMC_ADDR_STAT, 0);
    chk(rd[3:1], 3'h4);
    chk(sel_n, 4'hf);
  end
  endtask
  task abort_byte;
  begin
    apb(1'b1, `SPIMC_ADDR_CTRL, {26'h0, 6'h26});
    apb(1'b1, `SPIMC_ADDR_TXD, 32'ha5);
    apb(1'b1, `SPIMC_ADDR_CTRL, {26'h0, 6'h06});
    apb(1'b0, `SPIMC_ADDR_STAT, 0);
    chk(rd[2:0], 3'h0);
    chk({sclk, sel_n}, 5'h0f);
  end
  endtask
  // Rates of three and up leave room for the two-flop input path.
  task xfer(input [5:0] c, input [7:0] m, input col);
  begin
    clock_idle_level <= c[3];
    clock_edge_phase <= c[4];
    stx <= ~m;
    apb(1'b1, `SPIMC_ADDR_CTRL, {27'h0, c[4:0]});
    apb(1'b1, `SPIMC_ADDR_CTRL, {26'h0, c});
    apb(1'b1, `SPIMC_ADDR_TXD, {24'h0, m});
    if (col)
      apb(1'b1, `SPIMC_ADDR_TXD, 32'h0);
    @(posedge sclk);
    n = 0;
    while (sclk)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk(n >= (1 << c[2:0]) && n <= (1 << c[2:0]) + 2, 1);
    apb(1'b0, `SPIMC_ADDR_STAT, 0);
    while (rd[`SPIMC_STAT_BUSY])
      apb(1'b0, `SPIMC_ADDR_STAT, 0);
    chk(rd[3:0], {1'b0, col, 2'b01});
    chk(srx, m);
    chk(sclk, c[3]);
    apb(1'b0, `SPIMC_ADDR_RXD, 0);
    chk(rd, {24'h0, ~m});
    apb(1'b0, `SPIMC_ADDR_STAT, 0);
    chk(rd[2:0], 3'h0);
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk({sclk, sel_n}, 5'h0f);
    apb(1'b0, `SPIMC_ADDR_CTRL, 0);
    chk(rd, {26'h0, `SPIMC_CTRL_RST});
    apb(1'b0, `SPIMC_ADDR_SEL, 0);
    chk(rd, {28'h0, `SPIMC_SEL_RST});
    apb(1'b0, 12'h020, 0);
    chk(er, 1'b1);
    apb(1'b1, `SPIMC_ADDR_SEL, 32'he);
    apb(1'b1, `SPIMC_ADDR_SEL, 32'h0);
    chk(er, 1'b1);
    apb(1'b0, `SPIMC_ADDR_SEL, 0);
    chk(rd, 32'he);
    bad_rate(`SPIMC_RATE_RES0);
    bad_rate(`SPIMC_RATE_RES7);
    abort_byte;
    // Polarity changes only from phase 0, where the select is high.
    for (i = 0; i < 4; i = i + 1)
      xfer({1'b1, ~(i[0] ^ i[1]), i[1], 3'h3 + i[2:0]}, 8'h1b + 8'h47 * i[7:0], i == 3);
    wrap_up;
  end
endmodule // tb
